// file: hdl/slif_sub_level_flags.v
// Sub-level system and charger event flags with the system mask register.
// Assumes a byte-wide register port whose full 8-bit offset is decoded in this block, and status inputs from analog monitors.
//
// Overview of operation
// RL1: Key held low past 5 ms sets bit 5
// RL2: Die heat at warning level sets bit 4
// RL3: Die heat at cutoff level sets bit 3
// RL4: System rail below warning sets bit 2
// RL5: Watchdog expiry sets and holds bit 1
// RL6: Input supply status change sets bit 0
// RL7: Flag registers 02h/04h reset zero, write-clear
// RL8: Mask register 03h read-write, 1 masks flag
// RL9: Mask bits 5..0 reset to 1, upper zero
// RL10: Dead charge timer expiry sets charger bit 6
// RL11: Input current limit sets charger bit 5
// RL12: Fast charge timer expiry sets bit 4
// RL13: Pre-charge timer expiry sets bit 3
// RL14: Cell presence change sets charger bit 2
// RL15: Cell level change sets charger bit 1
// RL16: Charger good change sets charger bit 0
// RL17: Group summary bits clear when groups empty
// RL18: Only first unmasked event asserts interrupt
// RL19: Write one clears; same-cycle event wins
// RL20: Masked events still flag, not interrupt
`timescale 1ns/100ps
`include "slif_defs.vh"

module slif_sub_level_flags #(
	parameter LONG_PRESS_CYC = `SLIF_LONG_PRESS_CYC
) (
	// Clock, reset and enable
	input  wire       clk,
	input  wire       reset,
	input  wire       clk_en,
	// Register port
	input  wire [7:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	// Pins from outside the clock domain
	input  wire       power_key_n,
	input  wire       die_heat_warn,
	input  wire       die_heat_cutoff,
	input  wire       sys_rail_low,
	input  wire       input_supply_ok,
	input  wire       cell_present_status,
	input  wire       cell_level_ok,
	input  wire       charger_good,
	// Event pulses from on-chip timers on this clock
	input  wire       watchdog_expired,
	input  wire       dead_charge_expired,
	input  wire       input_current_capped,
	input  wire       fast_charge_expired,
	input  wire       precharge_expired,
	// Summary and interrupt
	output reg        system_group_flag,
	output reg        charger_group_flag,
	output reg        irq_out_n
);

	localparam NSYNC = 8;

	// Two-stage synchronisers for the asynchronous status pins
	reg  [NSYNC-1:0] sync1_reg;
	reg  [NSYNC-1:0] sync2_reg;
	reg  [NSYNC-1:0] prev_reg;
	wire [NSYNC-1:0] raw_in;
	assign raw_in = {charger_good, cell_level_ok, cell_present_status, input_supply_ok,
		sys_rail_low, die_heat_cutoff, die_heat_warn, power_key_n};

	wire key_n_s     = sync2_reg[0];
	wire heat_warn_s = sync2_reg[1];
	wire heat_cut_s  = sync2_reg[2];
	wire rail_low_s  = sync2_reg[3];

	// Status-change detection on synchronised levels only
	wire [NSYNC-1:0] changed = sync2_reg ^ prev_reg;

	reg  [7:0]  sys_flags_reg;
	reg  [7:0]  sys_flags_next;
	reg  [7:0]  sys_mask_reg;
	reg  [7:0]  chg_flags_reg;
	reg  [7:0]  chg_flags_next;
	reg  [31:0] press_cnt_reg;
	reg         press_done_reg;
	reg         irq_pending_reg;
	reg  [7:0]  sys_evt;
	reg  [7:0]  chg_evt;
	reg  [7:0]  rdata_next;

	wire wr_sys_flags = reg_wr && (reg_addr == `SLIF_SYS_FLAGS_ADDR);
	wire wr_sys_mask  = reg_wr && (reg_addr == `SLIF_SYS_MASK_ADDR);
	wire wr_chg_flags = reg_wr && (reg_addr == `SLIF_CHG_FLAGS_ADDR);

	// Event set wins over a write-one clear in the same cycle
	function [7:0] flag_update;
		input [7:0] cur;
		input [7:0] evt;
		input       clr_en;
		input [7:0] clr;
		input [7:0] valid;
		begin
			flag_update = ((cur & ~(clr_en ? clr : 8'h00)) | evt) & valid;
		end
	endfunction

	// Long press: count key-low cycles since the falling edge, fire once per press
	wire press_fire = !key_n_s && !press_done_reg && (press_cnt_reg >= LONG_PRESS_CYC);

	always @* begin
		sys_evt = 8'h00;
		sys_evt[`SLIF_SYS_LONG_PRESS] = press_fire; // RL1
		sys_evt[`SLIF_SYS_HEAT_EARLY] = heat_warn_s; // RL2
		sys_evt[`SLIF_SYS_OVERHEAT]   = heat_cut_s; // RL3
		sys_evt[`SLIF_SYS_RAIL_LOW]   = rail_low_s; // RL4
		sys_evt[`SLIF_SYS_WATCHDOG]   = watchdog_expired; // RL5
		sys_evt[`SLIF_SYS_INPUT]      = changed[4]; // RL6
		chg_evt = 8'h00;
		chg_evt[`SLIF_CHG_DEAD_TIMER]   = dead_charge_expired; // RL10
		chg_evt[`SLIF_CHG_INPUT_CAP]    = input_current_capped; // RL11
		chg_evt[`SLIF_CHG_FAST_TIMER]   = fast_charge_expired; // RL12
		chg_evt[`SLIF_CHG_PRE_TIMER]    = precharge_expired; // RL13
		chg_evt[`SLIF_CHG_CELL_PRESENT] = changed[5]; // RL14
		chg_evt[`SLIF_CHG_CELL_LEVEL]   = changed[6]; // RL15
		chg_evt[`SLIF_CHG_GOOD]         = changed[7]; // RL16
	end

	always @* begin
		sys_flags_next = flag_update(sys_flags_reg, sys_evt, wr_sys_flags, reg_wdata,
			`SLIF_SYS_FLAG_BITS); // RL19
		chg_flags_next = flag_update(chg_flags_reg, chg_evt, wr_chg_flags, reg_wdata,
			`SLIF_CHG_FLAG_BITS); // RL19
	end

	// Only the system group carries a mask here; charger flags always count
	reg  [7:0] sys_mask_next;
	always @* begin
		sys_mask_next = sys_mask_reg;
		if (wr_sys_mask) begin
			sys_mask_next = reg_wdata; // RL8
		end
	end
	wire [7:0] sys_unmasked_next = sys_flags_next & ~sys_mask_next; // RL20

	wire any_unmasked_next = (|sys_unmasked_next) || (|chg_flags_next);
	// New unmasked flag that was not already pending
	wire new_unmasked = ((|(sys_flags_next & ~sys_flags_reg & ~sys_mask_next)) ||
		(|(chg_flags_next & ~chg_flags_reg)) ||
		(|(sys_flags_reg & sys_mask_reg & ~sys_mask_next)));

	always @* begin
		case (reg_addr)
			`SLIF_SYS_FLAGS_ADDR: rdata_next = sys_flags_next;
			`SLIF_SYS_MASK_ADDR:  rdata_next = sys_mask_next;
			`SLIF_CHG_FLAGS_ADDR: rdata_next = chg_flags_next;
			default:              rdata_next = 8'h00;
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			// Idle levels: key and status high, level conditions low, so no false flag
			sync1_reg          <= 8'hF1;
			sync2_reg          <= 8'hF1;
			prev_reg           <= 8'hF1;
			press_cnt_reg      <= 32'h0000_0000;
			press_done_reg     <= 1'b0;
			sys_flags_reg      <= `SLIF_FLAGS_RESET; // RL7
			chg_flags_reg      <= `SLIF_FLAGS_RESET; // RL7
			sys_mask_reg       <= `SLIF_SYS_MASK_RESET; // RL9
			irq_pending_reg    <= 1'b0;
			reg_rdata          <= 8'h00;
			system_group_flag  <= 1'b0;
			charger_group_flag <= 1'b0;
			irq_out_n          <= 1'b1;
		end else if (clk_en) begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			// Counter saturates so a key held for minutes cannot wrap and refire
			if (key_n_s) begin
				press_cnt_reg  <= 32'h0000_0000;
				press_done_reg <= 1'b0;
			end else begin
				if (press_cnt_reg < LONG_PRESS_CYC) begin
					press_cnt_reg <= press_cnt_reg + 32'h0000_0001;
				end
				if (press_fire) begin
					press_done_reg <= 1'b1; // RL1
				end
			end
			sys_flags_reg <= sys_flags_next;
			chg_flags_reg <= chg_flags_next;
			sys_mask_reg  <= sys_mask_next;
			reg_rdata     <= rdata_next;
			system_group_flag  <= |sys_flags_next; // RL17
			charger_group_flag <= |chg_flags_next; // RL17
			// Interrupt stays low until no unmasked flag remains; repeats do not retrigger
			if (!any_unmasked_next) begin
				irq_pending_reg <= 1'b0;
				irq_out_n       <= 1'b1;
			end else if (new_unmasked || irq_pending_reg) begin
				irq_pending_reg <= 1'b1; // RL18
				irq_out_n       <= 1'b0; // RL20
			end
		end
	end

endmodule // slif_sub_level_flags

// file: hdl/slif_defs.vh
// Offsets, field positions, reset values and timing counts for the sub-level flag block.
// Included by the flag block; holds definitions only.
`ifndef SLIF_DEFS_VH
`define SLIF_DEFS_VH

// Register offsets
`define SLIF_SYS_FLAGS_ADDR   8'h02
`define SLIF_SYS_MASK_ADDR    8'h03
`define SLIF_CHG_FLAGS_ADDR   8'h04

// Reset values
`define SLIF_FLAGS_RESET      8'h00
`define SLIF_SYS_MASK_RESET   8'h3F

// System flag positions
`define SLIF_SYS_LONG_PRESS   5
`define SLIF_SYS_HEAT_EARLY   4
`define SLIF_SYS_OVERHEAT     3
`define SLIF_SYS_RAIL_LOW     2
`define SLIF_SYS_WATCHDOG     1
`define SLIF_SYS_INPUT        0

// Charger flag positions
`define SLIF_CHG_DEAD_TIMER   6
`define SLIF_CHG_INPUT_CAP    5
`define SLIF_CHG_FAST_TIMER   4
`define SLIF_CHG_PRE_TIMER    3
`define SLIF_CHG_CELL_PRESENT 2
`define SLIF_CHG_CELL_LEVEL   1
`define SLIF_CHG_GOOD         0

// Writable bit sets
`define SLIF_SYS_FLAG_BITS    8'h3F
`define SLIF_CHG_FLAG_BITS    8'h7F

// Summary bit positions
`define SLIF_TOP_SYS_GROUP    3
`define SLIF_TOP_CHG_GROUP    2

// Long press time: 5 ms at 100 MHz
`define SLIF_CLK_MHZ          100
`define SLIF_LONG_PRESS_US    5000
`define SLIF_LONG_PRESS_CYC   (`SLIF_LONG_PRESS_US * `SLIF_CLK_MHZ)

`endif

// file: testbench/slif_host_model.sv
// Host model: byte writes and reads on the flag block register port.
// Assumes the block samples on the rising edge; this model moves on the falling edge.
`timescale 1ns/100ps
module slif_host_model (
	// Register port
	input  wire        clk,
	output logic [7:0] reg_addr,
	output logic       reg_wr,
	output logic [7:0] reg_wdata,
	input  wire  [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'hFF;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Stale data is inverted so a late sample cannot pass by luck
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask
endmodule // slif_host_model

// file: testbench/slif_flags_sva.sv
// Checker for the flag block ports.
// Assumes clk_en is held high while checking.
`timescale 1ns/100ps
module slif_flags_sva (
	// Watched ports
	input wire       clk,
	input wire       reset,
	input wire [7:0] reg_addr,
	input wire       reg_wr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire       watchdog_expired,
	input wire       system_group_flag,
	input wire       charger_group_flag,
	input wire       irq_out_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wd_sets_flag_a: assert property (watchdog_expired |=> system_group_flag)
		else $error("watchdog left no flag");
	sys_read_a: assert property ($stable(reg_addr) && reg_addr == 8'h02 |->
		reg_rdata[7:6] == 2'b00 && (|reg_rdata) == system_group_flag)
		else $error("sys summary mismatch");
	chg_read_a: assert property ($stable(reg_addr) && reg_addr == 8'h04 |->
		!reg_rdata[7] && (|reg_rdata) == charger_group_flag)
		else $error("chg summary mismatch");
	irq_source_a: assert property (!irq_out_n |-> system_group_flag || charger_group_flag)
		else $error("irq without flag");
	chg_irq_a: assert property (charger_group_flag |-> !irq_out_n)
		else $error("chg flag without irq");
	clear_flag_a: assert property (reg_wr && reg_addr == 8'h02 && reg_wdata[1]
		&& !watchdog_expired |=> !reg_rdata[1])
		else $error("clear lost");
	event_wins_a: assert property (watchdog_expired && reg_addr == 8'h02 |=> reg_rdata[1])
		else $error("event lost");
	mask_write_a: assert property (reg_wr && reg_addr == 8'h03 |=>
		(reg_rdata & 8'h3F) == ($past(reg_wdata) & 8'h3F))
		else $error("mask readback");
	cover property (!irq_out_n);
	cover property (reg_wr && reg_addr == 8'h03);
	cover property (watchdog_expired && reg_wr);
endmodule // slif_flags_sva
bind slif_sub_level_flags slif_flags_sva i_sva (.clk(clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.watchdog_expired(watchdog_expired), .system_group_flag(system_group_flag),
	.charger_group_flag(charger_group_flag), .irq_out_n(irq_out_n));

// file: testbench/testbench.sv
// Self-checking bench for the flag block.
// Host model drives the register port; the bench drives event pins.
`timescale 1ns/100ps
module testbench;
	logic        clk;
	logic        reset;
	logic [12:0] ev;
	logic [7:0]  d, a, x;
	logic        c;
	wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
	wire         reg_wr, sys_grp, chg_grp, irq_n;
	int          err_count, num_checks;
	// Key and status pins idle high so reset release sees no change
	wire  [12:0] pin = ev ^ 13'h1107;
	logic [15:0] rows [13] = '{16'h0200, 16'h0210, 16'h0208, 16'h0204, 16'h0201, 16'h0202,
		16'h0440, 16'h0420, 16'h0410, 16'h0408, 16'h0404, 16'h0402, 16'h0401};
	slif_sub_level_flags #(.LONG_PRESS_CYC(20)) i_dut (.clk(clk), .reset(reset), .clk_en(1'b1),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.power_key_n(pin[12]), .die_heat_warn(pin[11]), .die_heat_cutoff(pin[10]),
		.sys_rail_low(pin[9]), .input_supply_ok(pin[8]), .watchdog_expired(pin[7]),
		.dead_charge_expired(pin[6]), .input_current_capped(pin[5]),
		.fast_charge_expired(pin[4]), .precharge_expired(pin[3]),
		.cell_present_status(pin[2]), .cell_level_ok(pin[1]), .charger_good(pin[0]),
		.system_group_flag(sys_grp), .charger_group_flag(chg_grp), .irq_out_n(irq_n));
	slif_host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rc(input string n, input logic [7:0] ad, input logic [7:0] e);
		i_host.rd(ad, d);
		chk(n, d, e);
	endtask
	task automatic tog(input int b, input int n);
		ev[b] = 1'b1;
		repeat (n) @(negedge clk);
		ev[b] = 1'b0;
		repeat (6) @(negedge clk);
	endtask
	task automatic rst_chk;
		rc("sys", 8'h02, 8'h00);
		rc("mask", 8'h03, 8'h3F);
		rc("chg", 8'h04, 8'h00);
		rc("unmapped", 8'h10, 8'h00);
		chk("pins", {5'h00, sys_grp, chg_grp, irq_n}, 8'h01);
		$display("reset test done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		err_count++;
		test_done();
	end
	initial begin
		reset = 1'b1;
		ev = '0;
		err_count = 0;
		num_checks = 0;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		rst_chk();
		for (int i = 0; i < 13; i++) begin
			a = rows[i][15:8];
			x = rows[i][7:0];
			c = (a == 8'h04);
			tog(12 - i, 4);
			rc("flag", a, x);
			chk("group", {5'h00, sys_grp, chg_grp, irq_n}, {5'h00, x != 0 && !c, x != 0 && c, !(x != 0 && c)});
			i_host.wr(a, x);
			rc("cleared", a, 8'h00);
			chk("idle", {5'h00, sys_grp, chg_grp, irq_n}, 8'h01);
			$display("row %0d done", i);
		end
		tog(12, 30);
		rc("press", 8'h02, 8'h20);
		i_host.wr(8'h02, 8'h20);
		tog(7, 1);
		chk("masked", {7'h00, irq_n}, 8'h01);
		i_host.wr(8'h03, 8'h3D);
		chk("unmasked", {7'h00, irq_n}, 8'h00);
		tog(7, 1);
		rc("repeat", 8'h02, 8'h02);
		i_host.wr(8'h02, 8'h00);
		rc("zero write", 8'h02, 8'h02);
		fork
			i_host.wr(8'h02, 8'h02);
			tog(7, 2);
		join
		rc("race", 8'h02, 8'h02);
		i_host.wr(8'h02, 8'h02);
		chk("released", {7'h00, irq_n}, 8'h01);
		rc("mask", 8'h03, 8'h3D);
		$display("mask test done");
		tog(6, 1);
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		rst_chk();
		test_done();
	end
endmodule // testbench
